// ==== rtl/apv_pkg.sv ====
// constants for the auxiliary pin and video path register bank
package apv_pkg;

  // ******************************************************************
  // register offsets
  // ******************************************************************
  localparam logic [7:0] APV_PIN_PAIR_A_OFS = 8'h10;
  localparam logic [7:0] APV_PIN_PAIR_B_OFS = 8'h11;
  localparam logic [7:0] APV_VIDEO_PATH_OFS = 8'h12;

  // ******************************************************************
  // reset values and writable masks
  // ******************************************************************
  localparam logic [7:0] APV_PIN_PAIR_RST = 8'h00;
  localparam logic [7:0] APV_VIDEO_PATH_RST = 8'h00;
  localparam logic [7:0] APV_PIN_PAIR_MASK = 8'hbb;
  localparam logic [7:0] APV_VIDEO_PATH_MASK = 8'h7f;

  // ******************************************************************
  // pin pair field positions
  // ******************************************************************
  localparam int APV_LO_MODE_LSB = 0;
  localparam int APV_LO_VAL_BIT = 3;
  localparam int APV_HI_MODE_LSB = 4;
  localparam int APV_HI_VAL_BIT = 7;

  // ******************************************************************
  // video path field positions
  // ******************************************************************
  localparam int APV_PASSTHRU_BIT = 6;
  localparam int APV_VALID_POL_BIT = 5;
  localparam int APV_AUDIO_REGEN_BIT = 4;
  localparam int APV_CH2_OVERRIDE_BIT = 3;
  localparam int APV_COLOUR18_BIT = 2;
  localparam int APV_TRANSPORT_BIT = 1;
  localparam int APV_CH2_ENABLE_BIT = 0;

  // ******************************************************************
  // pin modes
  // ******************************************************************
  typedef enum logic [1:0] {
    APV_MODE_FUNC_IN = 2'b00,
    APV_MODE_GP_OUT = 2'b01,
    APV_MODE_HIZ = 2'b10,
    APV_MODE_GP_IN = 2'b11
  } apv_pin_mode_t;

endpackage

// ==== rtl/apv_pin_cell.sv ====
// one auxiliary pin: mode decode and registered pad control
`timescale 1ns/100ps
`default_nettype none
module apv_pin_cell
  import apv_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] mode_i,
  input wire logic value_i,
  input wire logic pad_in_i,
  output logic pad_out_o,
  output logic pad_oe_n_o,
  output logic func_in_o,
  output logic gp_in_o
);

  logic pad_out_d, pad_out_q;
  logic pad_oe_n_d, pad_oe_n_q;
  logic func_in_d, func_in_q;
  logic gp_in_d, gp_in_q;

  always_comb begin
    pad_out_d = 1'b0;
    pad_oe_n_d = 1'b1;
    func_in_d = 1'b0;
    gp_in_d = gp_in_q;
    unique case (apv_pin_mode_t'(mode_i))
      APV_MODE_FUNC_IN: begin
        func_in_d = pad_in_i;
      end
      APV_MODE_GP_OUT: begin
        pad_out_d = value_i;
        pad_oe_n_d = 1'b0;
      end
      APV_MODE_HIZ: begin
        pad_oe_n_d = 1'b1;
      end
      APV_MODE_GP_IN: begin
        gp_in_d = pad_in_i;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pad_out_q <= 1'b0;
      pad_oe_n_q <= 1'b1;
      func_in_q <= 1'b0;
      gp_in_q <= 1'b0;
    end else begin
      pad_out_q <= pad_out_d;
      pad_oe_n_q <= pad_oe_n_d;
      func_in_q <= func_in_d;
      gp_in_q <= gp_in_d;
    end
  end

  assign pad_out_o = pad_out_q;
  assign pad_oe_n_o = pad_oe_n_q;
  assign func_in_o = func_in_q;
  assign gp_in_o = gp_in_q;

endmodule // apv_pin_cell
`default_nettype wire

// ==== rtl/apv_regs.sv ====
// auxiliary pin configuration and video path control register bank
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - output-mode pin drives its stored value
// - mode 00 functional input, 10 high impedance
// - mode 01 gp output, 11 gp input
// - pin pairs at 0x10 and 0x11 layout
// - pin fields reset to zero
// - passthrough sends pixels regardless of valid strobe
// - passthrough blocks encryption and packet audio
// - bit 5 selects valid strobe polarity
// - bit 4 selects repeater audio regeneration source
// - override bit gates second audio channel enable
// - bit 2 selects 18 or 24-bit colour
// - bit 0 enables second audio channel
module apv_regs
  import apv_pkg::*;
#(
  parameter int PIX_W = 24,
  parameter int NUM_PINS = 4
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [NUM_PINS-1:0] aux_pin_in_i,
  output logic [NUM_PINS-1:0] aux_pin_out_o,
  output logic [NUM_PINS-1:0] aux_pin_oe_n_o,
  output logic [NUM_PINS-1:0] aux_pin_func_o,
  output logic [NUM_PINS-1:0] aux_pin_gp_in_o,
  input wire logic pixel_valid_strobe_i,
  input wire logic [PIX_W-1:0] pixel_data_i,
  output logic pixel_send_o,
  output logic [PIX_W-1:0] pixel_data_o,
  output logic encrypt_allow_o,
  output logic audio_packet_allow_o,
  output logic audio_regen_sel_o,
  output logic second_audio_channel_en_o,
  output logic colour_18bit_o,
  output logic audio_transport_sel_o
);

  // ******************************************************************
  // register storage
  // ******************************************************************
  logic [7:0] pair_a_d, pair_a_q;
  logic [7:0] pair_b_d, pair_b_q;
  logic [7:0] vpath_d, vpath_q;
  logic [7:0] rdata_d, rdata_q;
  logic rvalid_d, rvalid_q;

  always_comb begin
    pair_a_d = pair_a_q;
    pair_b_d = pair_b_q;
    vpath_d = vpath_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        APV_PIN_PAIR_A_OFS: pair_a_d = reg_wdata_i & APV_PIN_PAIR_MASK;
        APV_PIN_PAIR_B_OFS: pair_b_d = reg_wdata_i & APV_PIN_PAIR_MASK;
        APV_VIDEO_PATH_OFS: vpath_d = reg_wdata_i & APV_VIDEO_PATH_MASK;
        default: ;
      endcase
    end
  end

  always_comb begin
    rvalid_d = reg_rd_i;
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        APV_PIN_PAIR_A_OFS: rdata_d = pair_a_q;
        APV_PIN_PAIR_B_OFS: rdata_d = pair_b_q;
        APV_VIDEO_PATH_OFS: rdata_d = vpath_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pair_a_q <= APV_PIN_PAIR_RST;
      pair_b_q <= APV_PIN_PAIR_RST;
      vpath_q <= APV_VIDEO_PATH_RST;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      pair_a_q <= pair_a_d;
      pair_b_q <= pair_b_d;
      vpath_q <= vpath_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // ******************************************************************
  // pin cells
  // ******************************************************************
  logic [15:0] pin_cfg;
  assign pin_cfg = {pair_b_q, pair_a_q};

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    localparam int BASE = (p / 2) * 8 + ((p % 2 == 1) ? APV_HI_MODE_LSB : APV_LO_MODE_LSB);
    localparam int VBIT = (p / 2) * 8 + ((p % 2 == 1) ? APV_HI_VAL_BIT : APV_LO_VAL_BIT);
    apv_pin_cell u_cell (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .mode_i(pin_cfg[BASE +: 2]),
      .value_i(pin_cfg[VBIT]),
      .pad_in_i(aux_pin_in_i[p]),
      .pad_out_o(aux_pin_out_o[p]),
      .pad_oe_n_o(aux_pin_oe_n_o[p]),
      .func_in_o(aux_pin_func_o[p]),
      .gp_in_o(aux_pin_gp_in_o[p])
    );
  end

  // ******************************************************************
  // video and audio path control
  // ******************************************************************
  logic passthru, valid_active;
  logic send_d, send_q;
  logic [PIX_W-1:0] pix_d, pix_q;
  logic [PIX_W-1:0] colour18_mask;
  logic enc_d, enc_q, aud_d, aud_q;
  logic regen_d, regen_q, ch2_d, ch2_q;
  logic c18_d, c18_q, tsel_d, tsel_q;

  // 18-bit mode clears the two lsbs of each 8-bit colour
  for (genvar b = 0; b < PIX_W; b++) begin : g_mask
    assign colour18_mask[b] = ((b % 8) > 1);
  end

  always_comb begin
    passthru = vpath_q[APV_PASSTHRU_BIT];
    valid_active = pixel_valid_strobe_i ^ vpath_q[APV_VALID_POL_BIT];
    send_d = passthru | valid_active;
    c18_d = vpath_q[APV_COLOUR18_BIT];
    pix_d = send_d ? (c18_d ? (pixel_data_i & colour18_mask) : pixel_data_i) : '0;
    enc_d = ~passthru;
    aud_d = ~passthru;
    regen_d = vpath_q[APV_AUDIO_REGEN_BIT];
    ch2_d = vpath_q[APV_CH2_OVERRIDE_BIT] & vpath_q[APV_CH2_ENABLE_BIT];
    tsel_d = vpath_q[APV_TRANSPORT_BIT];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      send_q <= 1'b0;
      pix_q <= '0;
      enc_q <= 1'b1;
      aud_q <= 1'b1;
      regen_q <= 1'b0;
      ch2_q <= 1'b0;
      c18_q <= 1'b0;
      tsel_q <= 1'b0;
    end else begin
      send_q <= send_d;
      pix_q <= pix_d;
      enc_q <= enc_d;
      aud_q <= aud_d;
      regen_q <= regen_d;
      ch2_q <= ch2_d;
      c18_q <= c18_d;
      tsel_q <= tsel_d;
    end
  end

  assign pixel_send_o = send_q;
  assign pixel_data_o = pix_q;
  assign encrypt_allow_o = enc_q;
  assign audio_packet_allow_o = aud_q;
  assign audio_regen_sel_o = regen_q;
  assign second_audio_channel_en_o = ch2_q;
  assign colour_18bit_o = c18_q;
  assign audio_transport_sel_o = tsel_q;

endmodule // apv_regs
`default_nettype wire

// ==== verification/apv_regs_sva.sv ====
// checker for the aux pin and video path register bank
`timescale 1ns/100ps
`default_nettype none
module apv_regs_chk
  import apv_pkg::*;
#(
  parameter int PIX_W = 24,
  parameter int NUM_PINS = 4
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [NUM_PINS-1:0] aux_pin_in_i,
  input wire logic [NUM_PINS-1:0] aux_pin_out_o,
  input wire logic [NUM_PINS-1:0] aux_pin_oe_n_o,
  input wire logic [NUM_PINS-1:0] aux_pin_func_o,
  input wire logic [NUM_PINS-1:0] aux_pin_gp_in_o,
  input wire logic pixel_valid_strobe_i,
  input wire logic [PIX_W-1:0] pixel_data_i,
  input wire logic pixel_send_o,
  input wire logic [PIX_W-1:0] pixel_data_o,
  input wire logic encrypt_allow_o,
  input wire logic audio_regen_sel_o,
  input wire logic second_audio_channel_en_o,
  input wire logic colour_18bit_o
);
  logic [7:0] pa_q, pb_q, vp_q, rx;
  logic [3:0] drv, fin, vl, gpm;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {pa_q, pb_q, vp_q} <= 24'h0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h10) pa_q <= reg_wdata_i & 8'hbb;
      if (reg_addr_i == 8'h11) pb_q <= reg_wdata_i & 8'hbb;
      if (reg_addr_i == 8'h12) vp_q <= reg_wdata_i & 8'h7f;
    end
  end
  assign vl = {pb_q[7], pb_q[3], pa_q[7], pa_q[3]};
  assign drv = {pb_q[5:4] == 2'h1, pb_q[1:0] == 2'h1, pa_q[5:4] == 2'h1, pa_q[1:0] == 2'h1};
  assign fin = {~|pb_q[5:4], ~|pb_q[1:0], ~|pa_q[5:4], ~|pa_q[1:0]};
  assign gpm = {&pb_q[5:4], &pb_q[1:0], &pa_q[5:4], &pa_q[1:0]};
  assign rx = reg_addr_i == 8'h10 ? pa_q : reg_addr_i == 8'h11 ? pb_q :
    reg_addr_i == 8'h12 ? vp_q : 8'h00;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rd;
    reg_rd_i |=> reg_rvalid_o && reg_rdata_o == $past(rx);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read answer");
  property p_rsv;
    reg_rd_i && reg_addr_i[7:1] == 7'h08 |=> (reg_rdata_o & 8'h44) == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_oe;
    $past(nrst_i) |-> aux_pin_oe_n_o == ~$past(drv);
  endproperty
  a_oe: assert property (p_oe) else $error("bad pad enable");
  property p_out;
    $past(nrst_i) |-> ((aux_pin_out_o ^ $past(vl)) & $past(drv)) == 4'h0;
  endproperty
  a_out: assert property (p_out) else $error("bad pad value");
  property p_func;
    $past(nrst_i) |-> aux_pin_func_o == $past(aux_pin_in_i & fin);
  endproperty
  a_func: assert property (p_func) else $error("bad func input");
  property p_gp;
    $past(nrst_i) |-> aux_pin_gp_in_o ==
      $past((aux_pin_in_i & gpm) | (aux_pin_gp_in_o & ~gpm));
  endproperty
  a_gp: assert property (p_gp) else $error("bad gp input");
  property p_send;
    $past(nrst_i) |-> pixel_send_o == $past(vp_q[6] | (pixel_valid_strobe_i ^ vp_q[5]));
  endproperty
  a_send: assert property (p_send) else $error("bad send");
  property p_data;
    pixel_send_o |-> pixel_data_o == $past(pixel_data_i & (vp_q[2] ? 24'hfcfcfc : 24'hffffff));
  endproperty
  a_data: assert property (p_data) else $error("bad pixel data");
  property p_ctl;
    $past(nrst_i) |-> {encrypt_allow_o, audio_regen_sel_o, second_audio_channel_en_o,
      colour_18bit_o} == $past({~vp_q[6], vp_q[4], vp_q[3] & vp_q[0], vp_q[2]});
  endproperty
  a_ctl: assert property (p_ctl) else $error("bad path control");
endmodule // apv_regs_chk
bind apv_regs apv_regs_chk #(.PIX_W(PIX_W), .NUM_PINS(NUM_PINS)) chk_u (.*);
`default_nettype wire

// ==== verification/apv_host.sv ====
// host model driving the register port
`timescale 1ns/100ps
`default_nettype none
module apv_host (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge ref_clk_i);
    #1;
    {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
    @(posedge ref_clk_i);
    #1;
    {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
    q = rvalid_i ? rdata_i : 8'hxx;
  endtask
endmodule // apv_host
`default_nettype wire

// ==== verification/apv_regs_tb_top.sv ====
// self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module apv_regs_tb_top;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, pixel_send_o, encrypt_allow_o, audio_packet_allow_o;
  logic audio_regen_sel_o, second_audio_channel_en_o, colour_18bit_o, audio_transport_sel_o;
  logic pixel_valid_strobe_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q, v;
  logic [3:0] aux_pin_in_i = 4'h0;
  logic [3:0] aux_pin_out_o, aux_pin_oe_n_o, aux_pin_func_o, aux_pin_gp_in_o;
  logic [23:0] pixel_data_i = 24'h0;
  logic [23:0] pixel_data_o;
  logic [31:0] s = 32'hd182;
  logic e;
  int errors = 0;
  int n_compared = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  apv_regs dut_u (.*);
  apv_host host_u (.ref_clk_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] a);
    return a[7:1] == 7'h08 ? 8'hbb : (a == 8'h12 ? 8'h7f : 8'h00);
  endfunction
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    chk("oe_rst", 4'hf, aux_pin_oe_n_o);
    for (int i = 0; i < 16; i++) begin
      s = lfsr(s);
      v = 8'h0f + 8'(i % 4);
      host_u.xfer(1'b0, v, 8'h00, q);
      if (i < 4) chk("rst", 8'h00, q);
      host_u.xfer(1'b1, v, s[7:0], q);
      host_u.xfer(1'b0, v, 8'h00, q);
      chk("rw", s[7:0] & msk(v), q);
    end
    for (int m = 0; m < 4; m++) begin
      s = lfsr(s);
      aux_pin_in_i = s[3:0];
      v = {s[5], 1'b1, 2'(m), s[4], 1'b1, 2'(m)};
      host_u.xfer(1'b1, 8'h10, v, q);
      host_u.xfer(1'b1, 8'h11, v ^ 8'h88, q);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("oe", {4{m != 1}}, aux_pin_oe_n_o);
      chk("out", m == 1 ? {~s[5:4], s[5:4]} : 4'h0, aux_pin_out_o & ~aux_pin_oe_n_o);
      chk("func", m == 0 ? s[3:0] : 4'h0, aux_pin_func_o);
      if (m == 3) chk("gp", s[3:0], aux_pin_gp_in_o);
    end
    for (int i = 0; i < 24; i++) begin
      s = lfsr(s);
      v = i == 0 ? 8'h7f : (i == 1 ? 8'h09 : s[7:0]);
      host_u.xfer(1'b1, 8'h12, v, q);
      repeat (3) begin
        s = lfsr(s);
        {pixel_data_i, pixel_valid_strobe_i} = s[24:0];
        e = v[6] | (s[0] ^ v[5]);
        @(posedge ref_clk_i);
        #1;
        chk("send", 1'(e), pixel_send_o);
        chk("pix", e ? s[24:1] & (v[2] ? 24'hfcfcfc : 24'hffffff) : 24'h0, pixel_data_o);
        chk("ctl", {~v[6], ~v[6], v[4], v[3] & v[0], v[2], v[1]}, {encrypt_allow_o,
          audio_packet_allow_o, audio_regen_sel_o, second_audio_channel_en_o, colour_18bit_o,
          audio_transport_sel_o});
      end
    end
    nrst_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    host_u.xfer(1'b0, 8'h12, 8'h00, q);
    chk("rst2", 8'h00, q);
    give_verdict();
  end
endmodule // apv_regs_tb_top
`default_nettype wire
